// File: design/dpmb_top.sv
// dual port mailbox between local processor and external host
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_map.svh"
module dpmb_top
  import dpmb_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // operating mode
  input  wire logic        single_chip_i,
  input  wire logic        hw_standby_i,
  input  wire logic        sw_standby_i,
  // local processor bus
  input  wire logic [15:0] loc_addr_i,
  input  wire logic        loc_rd_i,
  input  wire logic        loc_wr_i,
  input  wire logic [7:0]  loc_wdata_i,
  output logic [7:0]       loc_rdata_o,
  output logic             loc_ack_o,
  // host pins
  input  wire logic        host_cs_n_i,
  input  wire logic        host_oe_n_i,
  input  wire logic        host_we_n_i,
  input  wire logic [3:0]  host_register_select_i,
  input  wire logic [7:0]  host_data_bus_i,
  output logic [7:0]       host_data_bus_o,
  output logic             host_data_bus_oe_o,
  output logic             handshake_o,
  output logic             handshake_oe_o,
  // pin ownership and interrupts
  output logic             pins_taken_o,
  output logic             host_write_done_irq_o,
  output logic             host_read_done_irq_o
);
  logic [7:0]      data_mem [1:14];   // shared data bytes
  logic [7:0]      outbound_first_byte;
  logic [7:0]      inbound_first_byte;
  logic [7:0]      status_reg;        // mailbox_status_control
  logic            mailbox_enable;    // system_config enable bit
  logic            hs_low_reg;        // handshake drive state
  logic            loc_ack_reg;
  logic [7:0]      loc_rdata_reg;
  dpmb_bus_state_t bus_state;
  logic [1:0]      wait_cnt;
  dpmb_host_req_t  hreq;
  logic            host_rd_active;
  logic            enabled;
  logic            standby;
  logic            l_rd, l_wr;        // one-cycle local strobes
  logic            l_sel_cfg, l_sel_st, l_sel_first, l_sel_data;
  logic            h_rd, h_wr;
  logic [3:0]      l_idx;

  // is the address within the mailbox data window
  function automatic logic in_data(input logic [15:0] a);
    in_data = (a >= `DPMB_ADDR_DATA_LO) && (a <= `DPMB_ADDR_DATA_HI);
  endfunction

  // data index from a host select code
  function automatic logic [3:0] sel_to_idx(input logic [3:0] s);
    sel_to_idx = s - 4'h1;
  endfunction

  dpmb_host_sync u_sync (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .cs_n_i      (host_cs_n_i),
    .oe_n_i      (host_oe_n_i),
    .we_n_i      (host_we_n_i),
    .sel_i       (host_register_select_i),
    .data_i      (host_data_bus_i),
    .req_o       (hreq),
    .rd_active_o (host_rd_active)
  );

  assign standby     = hw_standby_i | sw_standby_i;
  assign enabled     = mailbox_enable & single_chip_i;
  assign h_rd        = hreq.rd & enabled;
  assign h_wr        = hreq.wr & enabled;
  assign l_sel_cfg   = (loc_addr_i == `DPMB_ADDR_SYSCFG);
  assign l_sel_st    = (loc_addr_i == `DPMB_ADDR_STATUS);
  assign l_sel_first = (loc_addr_i == `DPMB_ADDR_FIRST);
  assign l_sel_data  = in_data(loc_addr_i);
  assign l_idx       = loc_addr_i[3:0] - 4'h1;
  // local strobes fire when the bus cycle completes
  assign l_rd        = (bus_state == DPMB_DONE) && loc_rd_i;
  assign l_wr        = (bus_state == DPMB_DONE) && loc_wr_i;

  // three-state access sequencer for every mailbox byte
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state <= DPMB_IDLE;
      wait_cnt  <= 2'h0;
    end else begin
      unique case (bus_state)
        DPMB_IDLE: begin
          // any mapped address starts a cycle; the ack cycle is skipped so a
          // request still held at the ack edge is not taken a second time
          if ((loc_rd_i || loc_wr_i) && !loc_ack_reg
              && (l_sel_cfg || l_sel_st || l_sel_first || l_sel_data)) begin
            bus_state <= DPMB_WAIT;
            wait_cnt  <= 2'h0;
          end
        end
        DPMB_WAIT: begin
          wait_cnt <= wait_cnt + 2'h1;
          if (wait_cnt == `DPMB_MEM_WAIT - 2'h1) begin
            bus_state <= DPMB_DONE;
          end
        end
        DPMB_DONE: begin
          bus_state <= DPMB_IDLE;
        end
      endcase
    end
  end

  // local read data and acknowledge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      loc_ack_reg   <= 1'b0;
      loc_rdata_reg <= 8'h00;
    end else begin
      loc_ack_reg <= l_rd | l_wr;
      if (l_rd) begin
        if (l_sel_cfg) begin
          loc_rdata_reg <= {6'h00, mailbox_enable, 1'b0};
        end else if (l_sel_st) begin
          loc_rdata_reg <= status_reg;
        end else if (l_sel_first) begin
          loc_rdata_reg <= inbound_first_byte;
        end else begin
          loc_rdata_reg <= data_mem[l_idx];
        end
      end
    end
  end

  // mailbox enable bit in system configuration
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mailbox_enable <= 1'b0;
    end else if (hw_standby_i) begin
      mailbox_enable <= 1'b0;
    end else if (l_wr && l_sel_cfg) begin
      mailbox_enable <= loc_wdata_i[`DPMB_SYSCFG_EN_BIT];
    end
  end

  // first byte pair: each side writes only its own direction
  always_ff @(posedge ref_clk_i) begin
    if (l_wr && l_sel_first) begin
      outbound_first_byte <= loc_wdata_i;
    end
    if (h_wr && (hreq.sel == `DPMB_SEL_FIRST)) begin
      inbound_first_byte <= hreq.wdata;
    end
  end

  // data bytes; local wins a same-cycle clash, ownership normally prevents it
  always_ff @(posedge ref_clk_i) begin
    if (l_wr && l_sel_data && !status_reg[`DPMB_BIT_HOWN]) begin
      data_mem[l_idx] <= loc_wdata_i;
    end else if (h_wr && (hreq.sel > `DPMB_SEL_FIRST) && !status_reg[`DPMB_BIT_LOWN]) begin
      data_mem[sel_to_idx(hreq.sel)] <= hreq.wdata;
    end
  end

  // status and control bits; sets placed last so a set beats a clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= `DPMB_STATUS_RESET;
    end else if (standby) begin
      status_reg <= `DPMB_STATUS_RESET;
    end else begin
      // writable enables
      if (l_wr && l_sel_st) begin
        status_reg[`DPMB_BIT_HWIE] <= loc_wdata_i[`DPMB_BIT_HWIE];
        status_reg[`DPMB_BIT_HRIE] <= loc_wdata_i[`DPMB_BIT_HRIE];
        status_reg[`DPMB_BIT_HSE]  <= loc_wdata_i[`DPMB_BIT_HSE];
      end
      if (h_wr && (hreq.sel == `DPMB_SEL_STATUS)) begin
        status_reg[`DPMB_BIT_HSE] <= hreq.wdata[`DPMB_BIT_HSE];
      end
      // clears
      if (l_rd && (loc_addr_i == `DPMB_ADDR_DATA_HI)) begin
        status_reg[`DPMB_BIT_HWD] <= 1'b0;
      end
      if (h_rd && (hreq.sel == `DPMB_SEL_LAST)) begin
        status_reg[`DPMB_BIT_LWD] <= 1'b0;
      end
      if (((l_rd || l_wr) && l_sel_first) || (h_wr && (hreq.sel == `DPMB_SEL_FIRST))) begin
        status_reg[`DPMB_BIT_HRD] <= 1'b0;
      end
      if (l_rd && l_sel_first) begin
        status_reg[`DPMB_BIT_HOWN] <= 1'b0;
      end
      if (h_rd && (hreq.sel == `DPMB_SEL_FIRST)) begin
        status_reg[`DPMB_BIT_LOWN] <= 1'b0;
      end
      // sets
      if (h_wr && (hreq.sel == `DPMB_SEL_LAST) && !status_reg[`DPMB_BIT_LOWN]) begin
        status_reg[`DPMB_BIT_HWD] <= 1'b1;
      end
      if (l_wr && (loc_addr_i == `DPMB_ADDR_DATA_HI) && !status_reg[`DPMB_BIT_HOWN]) begin
        status_reg[`DPMB_BIT_LWD] <= 1'b1;
      end
      if (h_rd && (hreq.sel == `DPMB_SEL_FIRST)) begin
        status_reg[`DPMB_BIT_HRD] <= 1'b1;
      end
      // simultaneous first-byte writes: neither side gains ownership
      if (h_wr && (hreq.sel == `DPMB_SEL_FIRST) && !status_reg[`DPMB_BIT_LOWN]
          && !(l_wr && l_sel_first)) begin
        status_reg[`DPMB_BIT_HOWN] <= 1'b1;
      end
      if (l_wr && l_sel_first && !status_reg[`DPMB_BIT_HOWN]
          && !(h_wr && (hreq.sel == `DPMB_SEL_FIRST))) begin
        status_reg[`DPMB_BIT_LOWN] <= 1'b1;
      end
    end
  end

  // handshake state: release events checked before low events, high wins a tie
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_low_reg <= 1'b0;
    end else if (standby || !enabled || !status_reg[`DPMB_BIT_HSE]) begin
      hs_low_reg <= 1'b0;
    end else if ((h_rd && ((hreq.sel == `DPMB_SEL_LAST) || (hreq.sel == `DPMB_SEL_STATUS)))
                 || (h_wr && (hreq.sel == `DPMB_SEL_FIRST)) || (l_wr && l_sel_first)) begin
      hs_low_reg <= 1'b0;
    end else if ((l_rd && l_sel_first && status_reg[`DPMB_BIT_HOWN])
                 || (l_wr && (loc_addr_i == `DPMB_ADDR_DATA_HI))) begin
      hs_low_reg <= 1'b1;
    end
  end

  // registered pin outputs and interrupt requests
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_taken_o          <= 1'b0;
      handshake_o           <= 1'b0;
      handshake_oe_o        <= 1'b0;
      host_data_bus_o       <= 8'h00;
      host_data_bus_oe_o    <= 1'b0;
      host_write_done_irq_o <= 1'b0;
      host_read_done_irq_o  <= 1'b0;
    end else begin
      pins_taken_o       <= enabled;
      handshake_o        <= 1'b0;                // open drain: only ever pulls low
      handshake_oe_o     <= hs_low_reg;
      host_data_bus_oe_o <= enabled && host_rd_active;
      if (hreq.rd) begin
        unique case (hreq.sel)
          `DPMB_SEL_STATUS: host_data_bus_o <= status_reg;
          `DPMB_SEL_FIRST:  host_data_bus_o <= outbound_first_byte;
          default:          host_data_bus_o <= data_mem[sel_to_idx(hreq.sel)];
        endcase
      end
      host_write_done_irq_o <= status_reg[`DPMB_BIT_HWD] & status_reg[`DPMB_BIT_HWIE];
      host_read_done_irq_o  <= status_reg[`DPMB_BIT_HRD] & status_reg[`DPMB_BIT_HRIE];
    end
  end

  assign loc_rdata_o = loc_rdata_reg;
  assign loc_ack_o   = loc_ack_reg;
endmodule
`default_nettype wire

// File: design/dpmb_map.svh
// register addresses, field positions and reset values of the dual port mailbox
// Functional notes
// - enabled only in single-chip mode by enable bit
// - enabled mailbox takes over all host pins
// - enable bit clears on reset and hardware standby
// - first byte is two one-way registers
// - local always reaches data; host only enabled
// - disabled: data bytes are local memory, three states
// - status register clears on reset and standby
// - handshake enable both; irq enables local only
// - host writes last byte sets host write done
// - irq enable gates host write done request
// - local writes last byte sets local write done
// - handshake off or disabled: pin released
// - handshake low on owned read or last write
// - handshake released on host last or status reads, first writes
// - host read done set/cleared by first byte accesses
// - irq enable gates host read done request
// - host owns sets on host first write, free
// - host owns blocks local data writes
// - local owns sets on local first write, free
// - local owns blocks host data writes
// - select 0 status, 1 first byte, 2-15 data
`ifndef DPMB_MAP_SVH
`define DPMB_MAP_SVH
`define DPMB_ADDR_SYSCFG   16'hffc4
`define DPMB_ADDR_STATUS   16'hfff0
`define DPMB_ADDR_FIRST    16'hfff1
`define DPMB_ADDR_DATA_LO  16'hfff2
`define DPMB_ADDR_DATA_HI  16'hffff
`define DPMB_SYSCFG_EN_BIT 1
`define DPMB_SEL_STATUS    4'h0
`define DPMB_SEL_FIRST     4'h1
`define DPMB_SEL_LAST      4'hf
`define DPMB_STATUS_RESET  8'h00
`define DPMB_BIT_HWD       7
`define DPMB_BIT_HWIE      6
`define DPMB_BIT_LWD       5
`define DPMB_BIT_HSE       4
`define DPMB_BIT_HRD       3
`define DPMB_BIT_HRIE      2
`define DPMB_BIT_HOWN      1
`define DPMB_BIT_LOWN      0
`define DPMB_MEM_WAIT      2'h2
`endif

// File: design/dpmb_pkg.sv
// types shared by the dual port mailbox files
package dpmb_pkg;
  typedef struct packed {
    logic        rd;    // one-cycle read strobe
    logic        wr;    // one-cycle write strobe
    logic [3:0]  sel;   // register select
    logic [7:0]  wdata; // write data
  } dpmb_host_req_t;
  typedef enum logic [1:0] {
    DPMB_IDLE = 2'b00,
    DPMB_WAIT = 2'b01,
    DPMB_DONE = 2'b10
  } dpmb_bus_state_t;
endpackage

// File: design/dpmb_host_sync.sv
// host strobe synchroniser and access detector
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_map.svh"
module dpmb_host_sync
  import dpmb_pkg::*;
(
  // clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  // host pins
  input  wire logic           cs_n_i,
  input  wire logic           oe_n_i,
  input  wire logic           we_n_i,
  input  wire logic [3:0]     sel_i,
  input  wire logic [7:0]     data_i,
  // synchronised view
  output var dpmb_host_req_t  req_o,
  output logic                rd_active_o
);
  logic [2:0] s1_reg, s2_reg, s3_reg; // cs, oe, we stages
  logic       rd_act_reg, wr_act_reg; // filtered access levels
  logic [3:0] sel_reg;                // select captured at start
  logic       rd_lvl, wr_lvl;

  // three stage synchroniser; stage one feeds stage two only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
      s3_reg <= 3'h7;
    end else begin
      s1_reg <= {cs_n_i, oe_n_i, we_n_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // access counts only once stages two and three agree
  assign rd_lvl = (s2_reg == s3_reg) && !s2_reg[2] && !s2_reg[1];
  assign wr_lvl = (s2_reg == s3_reg) && !s2_reg[2] && !s2_reg[0];

  // edge detect: read acts at start, write at end (data settled)
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      sel_reg    <= 4'h0;
      req_o      <= '0;
    end else begin
      req_o.rd <= 1'b0;
      req_o.wr <= 1'b0;
      if ((s2_reg == s3_reg) && (rd_lvl != rd_act_reg)) begin
        rd_act_reg <= rd_lvl;
        if (rd_lvl) begin
          req_o.rd  <= 1'b1;
          req_o.sel <= sel_i;
        end
      end
      if ((s2_reg == s3_reg) && (wr_lvl != wr_act_reg)) begin
        wr_act_reg <= wr_lvl;
        if (wr_lvl) begin
          sel_reg <= sel_i;
        end else begin
          // data and select sampled while still held by the host
          req_o.wr    <= 1'b1;
          req_o.sel   <= sel_reg;
          req_o.wdata <= data_i;
        end
      end
    end
  end

  assign rd_active_o = rd_act_reg;
endmodule
`default_nettype wire

// File: tb/dpmb_top_sva.sv
// concurrent checks on the dual port mailbox ports
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_map.svh"
module dpmb_chk (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // mode and local bus
  input wire logic        single_chip_i,
  input wire logic        hw_standby_i,
  input wire logic        sw_standby_i,
  input wire logic [15:0] loc_addr_i,
  input wire logic        loc_rd_i,
  input wire logic        loc_wr_i,
  input wire logic        loc_ack_o,
  // host side
  input wire logic        host_cs_n_i,
  input wire logic        host_oe_n_i,
  input wire logic        host_data_bus_oe_o,
  input wire logic        handshake_oe_o,
  input wire logic        pins_taken_o,
  input wire logic        host_write_done_irq_o,
  input wire logic        host_read_done_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic req;  // any local request
  logic mapd; // address inside the mailbox map
  logic hrd;  // host read strobes low
  assign req = loc_rd_i | loc_wr_i;
  assign mapd = loc_addr_i == `DPMB_ADDR_SYSCFG || loc_addr_i >= `DPMB_ADDR_STATUS;
  assign hrd = !host_cs_n_i && !host_oe_n_i;
  // wait states, then a one-cycle acknowledge
  sequence s_wait;
    !loc_ack_o [*4];
  endsequence
  sequence s_ack;
    loc_ack_o ##1 !loc_ack_o;
  endsequence
  a_ack_timing: assert property ($rose(req) && mapd |-> s_wait ##1 s_ack)
    else $error("local ack timing wrong");
  a_unmapped_none: assert property (req && !mapd |-> !loc_ack_o)
    else $error("unmapped local access acked");
  a_mode_off: assert property (!single_chip_i |=> !pins_taken_o)
    else $error("pins taken outside single chip mode");
  a_standby_off: assert property (hw_standby_i |-> ##2 !pins_taken_o)
    else $error("pins taken in hardware standby");
  a_bus_idle: assert property (!pins_taken_o [*2] |-> !host_data_bus_oe_o)
    else $error("host bus driven while disabled");
  a_hs_idle: assert property (!pins_taken_o [*2] |-> !handshake_oe_o)
    else $error("handshake driven while disabled");
  a_status_clear: assert property (sw_standby_i ##1 sw_standby_i |=>
    !host_write_done_irq_o && !host_read_done_irq_o)
    else $error("request survives standby");
  a_read_oe: assert property ($rose(host_data_bus_oe_o) |-> $past(hrd) && $past(hrd, 3))
    else $error("host bus driven without read strobes");
  a_hwd_enabled: assert property ($rose(host_write_done_irq_o) |-> pins_taken_o)
    else $error("host write done while disabled");
endmodule
bind dpmb_top dpmb_chk u_chk (.ref_clk_i, .rst_i, .single_chip_i, .hw_standby_i, .sw_standby_i,
  .loc_addr_i, .loc_rd_i, .loc_wr_i, .loc_ack_o, .host_cs_n_i, .host_oe_n_i, .host_data_bus_oe_o,
  .handshake_oe_o, .pins_taken_o, .host_write_done_irq_o, .host_read_done_irq_o);
`default_nettype wire

// File: tb/dpmb_host_model.sv
// external host processor model on the mailbox pins
`timescale 1ns/1ps
`default_nettype none
module dpmb_host_model (
  // clock and resolved bus
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] bus_i,
  // host strobes and data
  output logic            cs_n_o,
  output logic            oe_n_o,
  output logic            we_n_o,
  output logic [3:0]      sel_o,
  output logic [7:0]      data_o
);
  // idle bus, strobes high
  initial begin
    {cs_n_o, oe_n_o, we_n_o} = 3'h7;
    sel_o = 4'h0;
    data_o = 8'hff;
  end
  // strobes low five cycles; data held past release
  task automatic host_write(input logic [3:0] s, input logic [7:0] d);
    @(negedge ref_clk_i);
    sel_o = s;
    data_o = d;
    {cs_n_o, we_n_o} = 2'h0;
    repeat (5) @(negedge ref_clk_i);
    {cs_n_o, we_n_o} = 2'h3;
    repeat (5) @(negedge ref_clk_i);
    data_o = ~d; // released bus never shows the old byte
    repeat (2) @(negedge ref_clk_i);
  endtask
  // no ready on this bus, so the byte is taken after a fixed access time
  task automatic host_read(input logic [3:0] s, output logic [7:0] d);
    @(negedge ref_clk_i);
    sel_o = s;
    {cs_n_o, oe_n_o} = 2'h0;
    repeat (8) @(negedge ref_clk_i);
    d = bus_i;
    {cs_n_o, oe_n_o} = 2'h3;
    repeat (6) @(negedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/dual_port_mailbox_test.sv
// self-checking bench for the dual port mailbox
`timescale 1ns/1ps
`default_nettype none
module dual_port_mailbox_test;
  // stimulus, all set at time zero
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        single_chip_i = 1'b0;
  logic        hw_standby_i = 1'b0;
  logic        sw_standby_i = 1'b0;
  logic [15:0] loc_addr_i = 16'h0000;
  logic        loc_rd_i = 1'b0;
  logic        loc_wr_i = 1'b0;
  logic [7:0]  loc_wdata_i = 8'h00;
  // design outputs and host pins
  logic [7:0]  loc_rdata_o, host_data_bus_o, host_data_bus_i, hdata;
  logic [3:0]  host_register_select_i;
  logic        loc_ack_o, host_cs_n_i, host_oe_n_i, host_we_n_i, host_data_bus_oe_o;
  logic        handshake_oe_o, pins_taken_o, host_write_done_irq_o, host_read_done_irq_o;
  logic        handshake_o;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // bus level seen by both sides
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : hdata;
  dpmb_top DUT (.ref_clk_i, .rst_i, .single_chip_i, .hw_standby_i, .sw_standby_i, .loc_addr_i,
    .loc_rd_i, .loc_wr_i, .loc_wdata_i, .loc_rdata_o, .loc_ack_o, .host_cs_n_i, .host_oe_n_i,
    .host_we_n_i, .host_register_select_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o,
    .handshake_o, .handshake_oe_o, .pins_taken_o, .host_write_done_irq_o, .host_read_done_irq_o);
  dpmb_host_model HOST (.ref_clk_i, .bus_i(host_data_bus_i), .cs_n_o(host_cs_n_i),
    .oe_n_o(host_oe_n_i), .we_n_o(host_we_n_i), .sel_o(host_register_select_i), .data_o(hdata));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // request held through the edge that samples ack, dropped on the falling edge after it
  task automatic loc(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge ref_clk_i);
    {loc_addr_i, loc_wdata_i, loc_wr_i, loc_rd_i} = {a, d, w, !w};
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (loc_ack_o !== 1'b1 && n < 12);
    q = loc_rdata_o;
    if (n >= 12)
      error_cnt++;
    @(negedge ref_clk_i);
    {loc_rd_i, loc_wr_i} = 2'h0;
    repeat (2) @(negedge ref_clk_i); // let flag effects land
  endtask
  task automatic lw(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    loc(a, 1'b1, d, q);
  endtask
  task automatic lr(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    loc(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic hw(input logic [3:0] s, input logic [7:0] d);
    HOST.host_write(s, d);
  endtask
  task automatic hr(input logic [3:0] s, input logic [7:0] e);
    logic [7:0] q;
    HOST.host_read(s, q);
    chk(q, e);
  endtask
  // disabled: local memory only, host ignored
  task automatic t_disabled();
    lr(16'hfff0, 8'h00);
    lr(16'hffc4, 8'h00);
    lw(16'hfff2, 8'ha5);
    hw(4'h2, 8'h33);
    lr(16'hfff2, 8'ha5);
    lw(16'hffc4, 8'h02);
    chk(pins_taken_o, 1'b0);
    single_chip_i = 1'b1;
    lw(16'hffc4, 8'h02);
    chk(pins_taken_o, 1'b1);
    $display("disabled test done");
  endtask
  // host sends; its ownership blocks local data writes
  task automatic t_host_send();
    lw(16'hfff0, 8'h54);
    hw(4'h0, 8'h00);
    lr(16'hfff0, 8'h44);
    hw(4'h0, 8'hff);
    lr(16'hfff0, 8'h54);
    hw(4'h1, 8'h3c);
    hr(4'h0, 8'h56);
    lw(16'hfff2, 8'h11);
    hw(4'h2, 8'h77);
    hw(4'hf, 8'h99);
    chk(host_write_done_irq_o, 1'b1);
    lr(16'hffff, 8'h99);
    chk(host_write_done_irq_o, 1'b0);
    lr(16'hfff2, 8'h77);
    lr(16'hfff1, 8'h3c);
    chk(handshake_oe_o, 1'b1);
    chk(handshake_o, 1'b0);
    lr(16'hfff0, 8'h54);
    $display("host send test done");
  endtask
  // local sends; its ownership blocks host data writes
  task automatic t_local_send();
    lw(16'hfff1, 8'hc3);
    chk(handshake_oe_o, 1'b0);
    hw(4'h2, 8'h22);
    lw(16'hfff2, 8'h5a);
    lw(16'hffff, 8'h6b);
    chk(handshake_oe_o, 1'b1);
    lr(16'hfff0, 8'h75);
    hr(4'hf, 8'h6b);
    chk(handshake_oe_o, 1'b0);
    lr(16'hfff0, 8'h55);
    hr(4'h2, 8'h5a);
    hr(4'h1, 8'hc3);
    chk(host_read_done_irq_o, 1'b1);
    lr(16'hfff0, 8'h5c);
    hr(4'h0, 8'h5c);
    lw(16'hfff0, 8'h10);
    chk(host_read_done_irq_o, 1'b0);
    lr(16'hfff1, 8'h3c);
    lr(16'hfff0, 8'h10);
    $display("local send test done");
  endtask
  // standby clears, unmapped address never acked
  task automatic t_standby();
    logic seen;
    sw_standby_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    sw_standby_i = 1'b0;
    lr(16'hfff0, 8'h00);
    lr(16'hffc4, 8'h02);
    hw_standby_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    hw_standby_i = 1'b0;
    lr(16'hffc4, 8'h00);
    loc_addr_i = 16'hff00;
    loc_rd_i = 1'b1;
    seen = 1'b0;
    repeat (8) @(negedge ref_clk_i) seen = seen | loc_ack_o;
    loc_rd_i = 1'b0;
    chk(seen, 1'b0);
    $display("standby test done");
  endtask
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_disabled();
    t_host_send();
    t_local_send();
    t_standby();
    close_out();
  end
  // watchdog, about fifty times the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
